//--- src/gpm_pkg.sv
// constants and types shared by the general-purpose port mode logic
package gpm_pkg;

    // ----------------------------------------------------------------
    // port geometry
    // ----------------------------------------------------------------
    localparam int NUM_PORTS = 3; // ports B, C and D
    localparam int PORT_WIDTH = 8; // pins per port
    localparam int ADDR_WIDTH = 8; // register address width
    localparam int MODE_WIDTH = 4; // control bits per pin

    // ----------------------------------------------------------------
    // register map: four registers per port, ports four apart
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_B_VALUE_OFS = 8'h9A; // first port base
    localparam logic [7:0] PORT_STRIDE = 8'h04; // distance between ports
    localparam logic [1:0] KIND_VALUE = 2'h0; // port_value_reg
    localparam logic [1:0] KIND_DIRECTION = 2'h1; // port_direction_reg
    localparam logic [1:0] KIND_ALT_ONE = 2'h2; // port_alt_select_one
    localparam logic [1:0] KIND_ALT_TWO = 2'h3; // port_alt_select_two

    // ----------------------------------------------------------------
    // reset values: code 0010 on every pin is plain input
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_ALT_ONE = 8'h00;
    localparam logic [7:0] RST_ALT_TWO = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00; // answer off the map

    // ----------------------------------------------------------------
    // mode codes {alt two, alt one, direction, value}
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_DRIVE_LOW = 4'h0;
    localparam logic [3:0] MODE_DRIVE_HIGH = 4'h1;
    localparam logic [3:0] MODE_INPUT_A = 4'h2;
    localparam logic [3:0] MODE_INPUT_B = 4'h3;
    localparam logic [3:0] MODE_DRAIN_LOW = 4'h4;
    localparam logic [3:0] MODE_DRAIN_OPEN = 4'h5;
    localparam logic [3:0] MODE_SOURCE_OPEN = 4'h6;
    localparam logic [3:0] MODE_SOURCE_HIGH = 4'h7;
    localparam logic [3:0] MODE_RESERVED = 4'h8;
    localparam logic [3:0] MODE_DUAL_EDGE = 4'h9;
    localparam logic [3:0] MODE_ALT_A = 4'hA;
    localparam logic [3:0] MODE_ALT_B = 4'hB;
    localparam logic [3:0] MODE_LEVEL_LOW = 4'hC;
    localparam logic [3:0] MODE_LEVEL_HIGH = 4'hD;
    localparam logic [3:0] MODE_FALL_EDGE = 4'hE;
    localparam logic [3:0] MODE_RISE_EDGE = 4'hF;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [PORT_WIDTH-1:0] gpm_byte_t;
    typedef logic [PORT_WIDTH-1:0][MODE_WIDTH-1:0] gpm_modes_t;

endpackage

//--- src/gpm_irq_port.sv
// pin sampling and interrupt detection for one 8-pin port
`timescale 1ns/1ps
`default_nettype none
module gpm_irq_port (
    input wire logic clock,
    input wire logic nrst,
    input wire gpm_pkg::gpm_byte_t pinIn, // pin levels, clock-synchronous
    input wire gpm_pkg::gpm_modes_t modeCode, // per-pin mode code
    input wire gpm_pkg::gpm_byte_t clrReq, // one-cycle write-one pulses
    output logic [gpm_pkg::PORT_WIDTH-1:0] pinSample, // sampled pin level
    output logic [gpm_pkg::PORT_WIDTH-1:0] irqReq // request per pin
);
    import gpm_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        gpm_byte_t smp; // pin level this cycle
        gpm_byte_t prev; // pin level one cycle earlier
        gpm_byte_t edgeFlag; // latched edge request
        gpm_byte_t irq; // request toward the core
    } gpm_irq_state_t;

    gpm_irq_state_t cur_ff;
    gpm_irq_state_t nxt_cur;

    // ----------------------------------------------------------------
    // detection
    // ----------------------------------------------------------------
    // a single sample stage: pins are already synchronous, and the
    // level check needs the current and previous sample anyway
    always_comb begin
        logic rise;
        logic fall;
        logic hit;
        logic lvl;
        logic isEdge;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        lvl = 1'b0;
        isEdge = 1'b0;
        nxt_cur = cur_ff;
        nxt_cur.smp = pinIn;
        nxt_cur.prev = cur_ff.smp;
        for (int i = 0; i < PORT_WIDTH; i++) begin
            rise = cur_ff.smp[i] & ~cur_ff.prev[i];
            fall = ~cur_ff.smp[i] & cur_ff.prev[i];
            // level matches stored bit in both of the last two samples
            lvl = (cur_ff.smp[i] == modeCode[i][0])
                && (cur_ff.prev[i] == modeCode[i][0]);
            unique case (modeCode[i])
                MODE_DUAL_EDGE: begin
                    isEdge = 1'b1;
                    hit = rise | fall;
                end
                MODE_FALL_EDGE: begin
                    isEdge = 1'b1;
                    hit = fall;
                end
                MODE_RISE_EDGE: begin
                    isEdge = 1'b1;
                    hit = rise;
                end
                default: begin
                    isEdge = 1'b0;
                    hit = 1'b0;
                end
            endcase
            // a new edge wins over a clear in the same cycle
            if (isEdge) begin
                nxt_cur.edgeFlag[i] = (cur_ff.edgeFlag[i] & ~clrReq[i]) | hit;
            end else begin
                nxt_cur.edgeFlag[i] = 1'b0;
            end
            unique case (modeCode[i])
                MODE_LEVEL_LOW, MODE_LEVEL_HIGH: nxt_cur.irq[i] = lvl;
                MODE_DUAL_EDGE, MODE_FALL_EDGE, MODE_RISE_EDGE:
                    nxt_cur.irq[i] = nxt_cur.edgeFlag[i];
                default: nxt_cur.irq[i] = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign pinSample = cur_ff.smp;
    assign irqReq = cur_ff.irq;

endmodule // gpm_irq_port
`default_nettype wire

//--- src/gpm_ports.sv
// three general-purpose ports: registers, pin drive and interrupts
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module gpm_ports (
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [gpm_pkg::ADDR_WIDTH-1:0] regAddr, // byte address
    input wire logic [gpm_pkg::PORT_WIDTH-1:0] regWrData, // write data
    input wire logic regWrEn, // one-cycle write strobe
    input wire logic regRdEn, // one-cycle read strobe
    output logic [gpm_pkg::PORT_WIDTH-1:0] regRdData, // next-cycle data
    // pins, index 0 is port B
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinIn,
    output logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinOut,
    output logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinOe,
    // alternate peripheral functions
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] altOut,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] altOe,
    output logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] altIn,
    // interrupt requests toward the vectored interrupt logic
    output logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] irqReq
);
    import gpm_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // control registers of all ports plus the registered outputs;
    // the index runs over ports B, C, D in that order
    typedef struct packed {
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] valueReg; // value bits
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] dirReg; // direction bits
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] altOneReg; // alt one bits
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] altTwoReg; // alt two bits
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] out; // pin output level
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] oe; // pin output enable
        logic [PORT_WIDTH-1:0] rdData; // read answer
    } gpm_state_t;

    gpm_state_t cur_ff; // registered state
    gpm_state_t nxt_cur; // next value of the state

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // returns {hit, port index, register kind}; used by the write and
    // the read path so the two can never disagree on the map
    function automatic logic [4:0] decodeAddr(input logic [ADDR_WIDTH-1:0] a);
        logic [ADDR_WIDTH-1:0] rel;
        logic [4:0] res;
        rel = a - PORT_B_VALUE_OFS;
        res = 5'h00;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (rel[ADDR_WIDTH-1:2] == p[ADDR_WIDTH-3:0]) begin
                res = {1'b1, p[1:0], rel[1:0]};
            end
        end
        // below the first port the subtraction wraps round
        if (a < PORT_B_VALUE_OFS) begin
            res = 5'h00;
        end
        return res;
    endfunction

    logic [4:0] dec; // decode of the current address
    logic decHit; // address lands on a register
    logic [1:0] decPort; // port addressed
    logic [1:0] decKind; // register within the port

    assign dec = decodeAddr(regAddr);
    assign decHit = dec[4];
    assign decPort = dec[3:2];
    assign decKind = dec[1:0];

    // ----------------------------------------------------------------
    // per-port interrupt detectors
    // ----------------------------------------------------------------
    logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pinSample; // sampled levels
    logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] clrReq; // write-one clears
    gpm_modes_t modeOf [NUM_PORTS]; // mode code of each pin

    // one detector per port, all alike
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
                // code order {alt two, alt one, direction, value}
                assign modeOf[p][i] = {cur_ff.altTwoReg[p][i],
                    cur_ff.altOneReg[p][i], cur_ff.dirReg[p][i],
                    cur_ff.valueReg[p][i]};
            end
            // a value-register write pulses the clear for each one bit;
            // the detector ignores it unless the pin is in an edge mode
            assign clrReq[p] = (regWrEn && decHit && decPort == 2'(p)
                && decKind == KIND_VALUE) ? regWrData : '0;
            gpm_irq_port u_irq (
                .clock(clock),
                .nrst(nrst),
                .pinIn(pinIn[p]),
                .modeCode(modeOf[p]),
                .clrReq(clrReq[p]),
                .pinSample(pinSample[p]),
                .irqReq(irqReq[p])
            );
        end
    endgenerate

    // the alternate function sees the same synchronous sample
    assign altIn = pinSample;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;

        // register writes, one byte per strobe
        if (regWrEn && decHit) begin
            unique case (decKind)
                KIND_VALUE: nxt_cur.valueReg[decPort] = regWrData;
                KIND_DIRECTION: nxt_cur.dirReg[decPort] = regWrData;
                KIND_ALT_ONE: nxt_cur.altOneReg[decPort] = regWrData;
                KIND_ALT_TWO: nxt_cur.altTwoReg[decPort] = regWrData;
            endcase
        end

        // read answer: valid only the cycle after the strobe
        nxt_cur.rdData = RD_UNMAPPED;
        if (regRdEn && decHit) begin
            unique case (decKind)
                // the value register reads the pins, never the stored bits
                KIND_VALUE: nxt_cur.rdData = pinSample[decPort];
                KIND_DIRECTION: nxt_cur.rdData = cur_ff.dirReg[decPort];
                KIND_ALT_ONE: nxt_cur.rdData = cur_ff.altOneReg[decPort];
                KIND_ALT_TWO: nxt_cur.rdData = cur_ff.altTwoReg[decPort];
            endcase
        end

        // pin drive, each pin on its own code; one cycle of latency
        // keeps every output on a flip-flop, alternate path included
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int i = 0; i < PORT_WIDTH; i++) begin
                unique case (modeOf[p][i])
                    MODE_DRIVE_LOW, MODE_DRIVE_HIGH: begin
                        nxt_cur.oe[p][i] = 1'b1;
                        nxt_cur.out[p][i] = cur_ff.valueReg[p][i];
                    end
                    MODE_DRAIN_LOW, MODE_DRAIN_OPEN: begin
                        // only a zero is driven; a one floats
                        nxt_cur.oe[p][i] = ~cur_ff.valueReg[p][i];
                        nxt_cur.out[p][i] = 1'b0;
                    end
                    MODE_SOURCE_OPEN, MODE_SOURCE_HIGH: begin
                        // only a one is driven; a zero floats
                        nxt_cur.oe[p][i] = cur_ff.valueReg[p][i];
                        nxt_cur.out[p][i] = 1'b1;
                    end
                    MODE_ALT_A, MODE_ALT_B: begin
                        nxt_cur.oe[p][i] = altOe[p][i];
                        nxt_cur.out[p][i] = altOut[p][i];
                    end
                    default: begin
                        // input, reserved and interrupt codes float
                        nxt_cur.oe[p][i] = 1'b0;
                        nxt_cur.out[p][i] = 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // reset code 0010 everywhere: plain input, no interrupt
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur_ff.valueReg <= {NUM_PORTS{RST_VALUE}};
            cur_ff.dirReg <= {NUM_PORTS{RST_DIRECTION}};
            cur_ff.altOneReg <= {NUM_PORTS{RST_ALT_ONE}};
            cur_ff.altTwoReg <= {NUM_PORTS{RST_ALT_TWO}};
            cur_ff.out <= '0;
            cur_ff.oe <= '0;
            cur_ff.rdData <= RD_UNMAPPED;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pinOut = cur_ff.out;
    assign pinOe = cur_ff.oe;
    assign regRdData = cur_ff.rdData;

endmodule // gpm_ports
`default_nettype wire

//--- test/gpm_ports_checker.sv
// checker: drive, read-back and interrupt relations of the three-port block
`timescale 1ns/1ps
`default_nettype none
module gpm_ports_checker (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [gpm_pkg::ADDR_WIDTH-1:0] regAddr,
    input wire logic [gpm_pkg::PORT_WIDTH-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [gpm_pkg::PORT_WIDTH-1:0] regRdData,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinIn,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinOut,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinOe,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] altOe,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] altIn,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] irqReq
);
    import gpm_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ----
    // shadow of the mode code of port B pin 0, rebuilt from register writes
    // ----
    wire logic [7:0] ofsB = regAddr - PORT_B_VALUE_OFS; // wraps, so one compare suffices
    logic [3:0] modeB0_ff; // {alt two, alt one, direction, value}
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            modeB0_ff <= {RST_ALT_TWO[0], RST_ALT_ONE[0], RST_DIRECTION[0], RST_VALUE[0]};
        end else if (regWrEn && ofsB < 8'h04) begin
            modeB0_ff[ofsB[1:0]] <= regWrData[0];
        end
    end
    a_reset_quiet: assert property (!$past(nrst) |-> pinOe == '0 && irqReq == '0)
        else $error("outputs active right after reset");
    a_read_idle: assert property (!$past(regRdEn) |-> regRdData == '0)
        else $error("read data not zero outside a read answer");
    a_read_sample: assert property (
        $past(regRdEn) && $past(regAddr) == PORT_B_VALUE_OFS |-> regRdData == $past(pinIn[0], 2))
        else $error("port B value read differs from sampled pins");
    a_alt_sample: assert property ($past(nrst) |-> altIn == $past(pinIn))
        else $error("alternate input is not the sampled pin");
    a_push_pull: assert property (
        $past(nrst) && $past(modeB0_ff[3:1]) == 3'h0
        |-> pinOe[0][0] == 1'b1 && pinOut[0][0] == $past(modeB0_ff[0]))
        else $error("push-pull pin not driving its value");
    a_open_drain: assert property (
        $past(nrst) && $past(modeB0_ff[3:1]) == 3'h2
        |-> pinOe[0][0] != $past(modeB0_ff[0]) && (pinOut[0][0] == 1'b0 || !pinOe[0][0]))
        else $error("open-drain pin drive wrong");
    a_open_source: assert property (
        $past(nrst) && $past(modeB0_ff[3:1]) == 3'h3
        |-> pinOe[0][0] == $past(modeB0_ff[0]) && (pinOut[0][0] == 1'b1 || !pinOe[0][0]))
        else $error("open-source pin drive wrong");
    a_float_modes: assert property (
        $past(nrst) && $past(modeB0_ff[3:1]) inside {3'h1, 3'h4, 3'h6, 3'h7} |-> !pinOe[0][0])
        else $error("pin driven in an undriven mode");
    a_alt_handover: assert property (
        $past(nrst) && $past(modeB0_ff[3:1]) == 3'h5 |-> pinOe[0][0] == $past(altOe[0][0]))
        else $error("alternate function does not own the enable");
    // the sample pair behind a request was taken two and three edges earlier
    a_level_two: assert property (
        $rose(irqReq[0][0]) && $past(modeB0_ff[3:1]) == 3'h6
        && $past(modeB0_ff, 3) == $past(modeB0_ff)
        |-> $past(pinIn[0][0], 2) == $past(modeB0_ff[0])
        && $past(pinIn[0][0], 3) == $past(modeB0_ff[0]))
        else $error("level request without two matching samples");
endmodule // gpm_ports_checker
bind gpm_ports gpm_ports_checker i_chk (.clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .altOe(altOe), .altIn(altIn),
    .irqReq(irqReq));
`default_nettype wire

//--- test/gpm_ext_devices.sv
// external devices and resistors on the 24 port pins
`timescale 1ns/1ps
`default_nettype none
module gpm_ext_devices (
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinOut,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinOe,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] extEn,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] extVal,
    input wire logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pullHigh,
    output logic [gpm_pkg::NUM_PORTS-1:0][gpm_pkg::PORT_WIDTH-1:0] pinIn
);
    import gpm_pkg::*;
    // the block wins, then an enabled device, else the resistor sets the level;
    // an undriven pin never keeps an old value
    always_comb begin
        pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn & pullHigh);
    end
endmodule // gpm_ext_devices
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the three-port mode logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gpm_pkg::*;
    typedef logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] gpm_pins_t; // one bit per pin
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    gpm_pins_t pinIn, pinOut, pinOe, altIn, irqReq;
    gpm_pins_t altOut = '0;
    gpm_pins_t altOe = '0;
    gpm_pins_t extEn = '0; // devices drive only where enabled
    gpm_pins_t extVal = '0;
    gpm_pins_t pullHigh = {8'h3C, 8'hC3, 8'h5A}; // resistor level per pin
    int fails = 0;
    int nCompared = 0;
    // value, direction, alt one, alt two, expected enable, expected driven level
    logic [5:0][7:0] modeTab [9] = '{{8'h69, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h69},
        {8'h3C, 8'h00, 8'hF0, 8'h00, 8'hCF, 8'h0C}, {8'h3C, 8'hFF, 8'hFF, 8'h00, 8'h3C, 8'h3C},
        {8'h3C, 8'h00, 8'hFF, 8'h00, 8'hC3, 8'h00}, {8'h3C, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00},
        {8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00}, {8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00},
        {8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00}, {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00}};
    always #2 clock = ~clock;
    gpm_ports i_dut (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .altOut(altOut), .altOe(altOe), .altIn(altIn),
        .irqReq(irqReq));
    gpm_ext_devices i_ext (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extVal(extVal),
        .pullHigh(pullHigh), .pinIn(pinIn));
    // ----
    // bus and check tasks
    // ----
    function automatic logic [7:0] ra(input int p, input logic [1:0] k);
        return PORT_B_VALUE_OFS + PORT_STRIDE * 8'(p) + {6'h00, k};
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrEn <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so look there
    task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRdEn <= 1'b0;
        #1 chk(what, regRdData, exp);
    endtask
    // value first, alt two last, so edge modes start with the value set
    task automatic setMode(input int p, input logic [7:0] v, d, a1, a2);
        wr(ra(p, KIND_VALUE), v);
        wr(ra(p, KIND_DIRECTION), d);
        wr(ra(p, KIND_ALT_ONE), a1);
        wr(ra(p, KIND_ALT_TWO), a2);
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic pinSet(input int p, input int i, input logic v);
        @(posedge clock);
        extVal[p][i] <= v;
    endtask
    task automatic irqChk(input string what, input int p, input logic [7:0] exp);
        repeat (4) @(posedge clock);
        #1 chk(what, irqReq[p], exp);
    endtask
    task automatic end_sim;
        if (fails == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        end_sim;
    end
    // ----
    // test sequence
    // ----
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            rdChk("direction", ra(p, KIND_DIRECTION), RST_DIRECTION);
            rdChk("alt one", ra(p, KIND_ALT_ONE), RST_ALT_ONE);
            rdChk("alt two", ra(p, KIND_ALT_TWO), RST_ALT_TWO);
            rdChk("input pins", ra(p, KIND_VALUE), pullHigh[p]);
            chk("reset enable", pinOe[p], 8'h00);
        end
        wr(8'hA6, 8'hAB);
        wr(8'h99, 8'hAB);
        rdChk("unmapped", 8'h99, RD_UNMAPPED);
        rdChk("unmapped", 8'hA6, RD_UNMAPPED);
        rdChk("last alt two", ra(2, KIND_ALT_TWO), RST_ALT_TWO);
        // every drive and input mode, the reserved code and codes 1001, 1100, 1111 on every port, including per-pin mixes
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int r = 0; r < 9; r++) begin
                setMode(p, modeTab[r][5], modeTab[r][4], modeTab[r][3], modeTab[r][2]);
                chk("enable", pinOe[p], modeTab[r][1]);
                chk("drive", pinOut[p] & pinOe[p], modeTab[r][0]);
                rdChk("pins", ra(p, KIND_VALUE),
                    modeTab[r][0] | (~modeTab[r][1] & pullHigh[p]));
            end
        end
        // alternate function owns the pins
        @(posedge clock);
        altOe <= {8'h0F, 8'hAA, 8'h55};
        altOut <= {8'hF0, 8'hF0, 8'hF0};
        for (int p = 0; p < NUM_PORTS; p++) begin
            // low nibble in code 1011, high nibble in 1010: value bit is ignored
            setMode(p, 8'h0F, 8'hFF, 8'h00, 8'hFF);
            chk("alt enable", pinOe[p], altOe[p]);
            chk("alt drive", pinOut[p] & pinOe[p], altOut[p] & altOe[p]);
            chk("alt input", altIn[p], (altOut[p] & altOe[p]) | (~altOe[p] & pullHigh[p]));
        end
        // low-level request on port B pin 0
        @(posedge clock);
        extEn <= {8'hFF, 8'hFF, 8'hFF};
        extVal <= {8'hF0, 8'h00, 8'hFF};
        setMode(0, 8'h00, 8'h00, 8'hFF, 8'hFF);
        pinSet(0, 0, 1'b0);
        pinSet(0, 0, 1'b1);
        irqChk("level pulse", 0, 8'h00);
        pinSet(0, 0, 1'b0);
        irqChk("level held", 0, 8'h01);
        pinSet(0, 0, 1'b1);
        irqChk("level gone", 0, 8'h00);
        // high-level request on the whole of port B, pins idle high
        setMode(0, 8'hFF, 8'h00, 8'hFF, 8'hFF);
        irqChk("level high", 0, 8'hFF);
        pinSet(0, 0, 1'b0);
        irqChk("high gone", 0, 8'hFE);
        // single-edge requests on port C pin 2
        setMode(1, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
        irqChk("edge idle", 1, 8'h00);
        pinSet(1, 2, 1'b1);
        irqChk("rising", 1, 8'h04);
        pinSet(1, 2, 1'b0);
        irqChk("rising kept", 1, 8'h04);
        wr(ra(1, KIND_VALUE), 8'hFB);
        irqChk("zero write", 1, 8'h04);
        wr(ra(1, KIND_VALUE), 8'hFF);
        irqChk("cleared", 1, 8'h00);
        wr(ra(1, KIND_VALUE), 8'hFB);
        pinSet(1, 2, 1'b1);
        irqChk("no rise", 1, 8'h00);
        pinSet(1, 2, 1'b0);
        irqChk("falling", 1, 8'h04);
        // dual-edge requests on port D pin 7
        setMode(2, 8'hFF, 8'h00, 8'h00, 8'hFF);
        irqChk("dual idle", 2, 8'h00);
        pinSet(2, 7, 1'b0);
        irqChk("dual fall", 2, 8'h80);
        wr(ra(2, KIND_VALUE), 8'hFF);
        irqChk("dual clear", 2, 8'h00);
        pinSet(2, 7, 1'b1);
        irqChk("dual rise", 2, 8'h80);
        // second reset with a request pending
        @(posedge clock);
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("reset request", irqReq[2], 8'h00);
        @(posedge clock);
        nrst <= 1'b1;
        rdChk("direction again", ra(2, KIND_DIRECTION), RST_DIRECTION);
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
